// file: verilog/cerc_consts.vh
// Purpose: Constants for the camera exposure and rate control register slice.
// Assumes: Byte-wide registers addressed by an 8-bit register index.
// Notes:   Offsets, reset values, field positions and the link command read bit live here.
`ifndef CERC_CONSTS_VH
`define CERC_CONSTS_VH

// Register offsets.
`define CERC_ADDR_STATS_CTRL     8'h29
`define CERC_ADDR_FR_ADJ_HI      8'h2a
`define CERC_ADDR_FR_ADJ_LO      8'h2b
`define CERC_ADDR_AUTO_BRIGHT    8'h2c
`define CERC_ADDR_EXP_FMT        8'h2d
`define CERC_ADDR_V_OFFSET       8'h2e
`define CERC_ADDR_DOUBLER_VREF   8'h2f
`define CERC_ADDR_VREF_CURRENT   8'h30
`define CERC_ADDR_WORK_MODE      8'h31
`define CERC_ADDR_DRIVE_STRENGTH 8'h32

// Reset values.
`define CERC_RST_STATS_CTRL      8'h34
`define CERC_RST_FR_ADJ_HI       8'h00
`define CERC_RST_FR_ADJ_LO       8'h00
`define CERC_RST_AUTO_BRIGHT     8'h88
`define CERC_RST_EXP_FMT         8'h81
`define CERC_RST_V_OFFSET        8'h20
`define CERC_RST_DOUBLER_VREF    8'h31
`define CERC_RST_VREF_CURRENT    8'h38
`define CERC_RST_WORK_MODE       8'h60
`define CERC_RST_DRIVE_STRENGTH  8'h06

// Field positions.
`define CERC_STATS_REV_MSB       1
`define CERC_STATS_CENTER_BIT    3
`define CERC_STATS_DBL_CLK_BIT   6
`define CERC_FRH_ENABLE_BIT      7
`define CERC_FRH_CTRL_MSB        6
`define CERC_FRH_CTRL_LSB        5
`define CERC_FRH_UV_DELAY_BIT    4
`define CERC_FRH_Y_MANUAL_BIT    3
`define CERC_FRH_ONE_FRAME_BIT   1
`define CERC_FRH_AVG_LUMA_BIT    0
`define CERC_EXP_SLOW_UPD_BIT    7
`define CERC_EXP_QUARTER_BIT     6
`define CERC_EXP_BLACK_EXP_BIT   4
`define CERC_EXP_BAND_BIT        2
`define CERC_VOFF_DIR_BIT        7

// Uv delay in pixels when enabled.
`define CERC_UV_DELAY_PIX        2'd2
// Frame rate step in hundredths of a percent per count.
`define CERC_FR_STEP_CENTI_PCT   4'd12
// Revision flag value, arbitrary.
`define CERC_REVISION            2'b00

// Serial link command byte: bit 7 high is a read, low bits unused.
`define CERC_CMD_READ_BIT        7
`endif

// file: verilog/cerc_regs.v
// Purpose: Register slice for exposure statistics, frame rate and V offset.
// Assumes: Host reaches registers by a serial link with clock and data pins.
// Notes:   Link pins are sampled by clk_sys_in; link clock must be slow.
`timescale 1ns/10ps
`include "cerc_consts.vh"

module cerc_regs (
    input  wire        clk_sys_in,         // System clock, 25 MHz.
    input  wire        nrst_in,            // Asynchronous reset, active low.
    input  wire        clk_en_in,          // Freezes all state except the reset synchroniser while low.
    input  wire        link_clk_in,        // Serial link clock pin.
    input  wire        link_data_in,       // Serial link data pin, input side.
    input  wire        link_sel_n_in,      // Serial link frame select, active low.
    input  wire        frame_exposure_in,  // Sensor is in frame exposure mode.
    input  wire        manual_bright_in,   // Manual brightness control bit.
    input  wire        offset_source_in,   // Offset source control bit.
    input  wire        raw_rgb_in,         // Output format is raw RGB.
    input  wire        field_start_in,     // One-cycle pulse at each field start.
    input  wire [7:0]  dark_share_in,      // Dark pixel share, 0.06% steps.
    input  wire [7:0]  int_v_offset_in,    // Internally computed V offset.
    output reg         link_data_out,      // Serial link data pin, output side.
    output reg         link_data_oe_out,   // Drive enable for the data pin.
    output reg         center_stats_out,   // Exposure uses central quarter.
    output reg         dbl_clk_out,        // Double clock rate option.
    output reg  [9:0]  fr_reduce_out,      // Applied frame rate reduction count.
    output reg  [13:0] fr_reduce_cpct_out, // Reduction in hundredths of percent.
    output reg  [1:0]  uv_delay_out,       // Chroma delay in pixels.
    output reg         y_manual_out,       // Manual luminance adjust active.
    output reg         one_frame_out,      // Single frame output active.
    output reg         avg_luma_out,       // Use internal luminance average.
    output reg         bright_dec_out,     // Brightness should decrease.
    output reg         bright_inc_out,     // Brightness should increase.
    output reg         exp_update_out,     // Exposure recalculation pulse.
    output reg         odd_field_only_out, // Odd fields only, interlaced.
    output reg         black_expand_out,   // Auto black expansion enabled.
    output reg         band_filter_out,    // Anti-banding exposure selected.
    output reg  [8:0]  v_offset_out,       // Signed V offset, zero if inactive.
    output reg         r_offset_sel_out    // Offset steers red channel.
);

    // Reset release and pin synchronisers.
    reg [1:0] rst_sync_reg;
    reg [1:0] clk_sync_reg;
    reg [1:0] dat_sync_reg;
    reg [1:0] sel_sync_reg;
    reg       clk_prev_reg;
    wire      rst_n;

    assign rst_n = rst_sync_reg[1];

    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    // Link pins pass two flops; only the second stage is read.
    always @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            clk_sync_reg <= 2'b00;
            dat_sync_reg <= 2'b00;
            sel_sync_reg <= 2'b11;
            clk_prev_reg <= 1'b0;
        end else if (clk_en_in) begin
            clk_sync_reg <= {clk_sync_reg[0], link_clk_in};
            dat_sync_reg <= {dat_sync_reg[0], link_data_in};
            sel_sync_reg <= {sel_sync_reg[0], link_sel_n_in};
            clk_prev_reg <= clk_sync_reg[1];
        end
    end

    wire clk_rise = clk_sync_reg[1] & ~clk_prev_reg;
    wire clk_fall = ~clk_sync_reg[1] & clk_prev_reg;
    wire sel_act  = ~sel_sync_reg[1];

    // Frame format: command byte, address byte, then one data byte in or out.
    localparam ST_CMD  = 2'd0;
    localparam ST_ADDR = 2'd1;
    localparam ST_DATA = 2'd2;
    localparam ST_DONE = 2'd3;

    reg [1:0] state_reg;
    reg [2:0] bit_cnt_reg;
    reg [7:0] shift_reg;
    reg       rd_reg;
    reg [7:0] addr_reg;
    reg [7:0] rd_data_reg;
    reg       wr_stb_reg;
    reg [7:0] wr_data_reg;

    reg [7:0] stats_ctrl_reg;
    reg [7:0] frame_rate_adj_hi_reg;
    reg [7:0] frame_rate_adj_lo_reg;
    reg [7:0] auto_bright_ratio_reg;
    reg [7:0] exposure_format_ctrl_reg;
    reg [7:0] v_chan_offset_reg;
    reg [7:0] doubler_vref_ctrl_reg;
    reg [7:0] vref_current_ctrl_reg;
    reg [7:0] sensor_work_mode_reg;
    reg [7:0] drive_strength_ctrl_reg;

    // Read mux; revision bits always show the fixed value.
    reg [7:0] rd_mux;
    always @* begin
        case (addr_reg)
            `CERC_ADDR_STATS_CTRL:     rd_mux = {stats_ctrl_reg[7:2], `CERC_REVISION};
            `CERC_ADDR_FR_ADJ_HI:      rd_mux = frame_rate_adj_hi_reg;
            `CERC_ADDR_FR_ADJ_LO:      rd_mux = frame_rate_adj_lo_reg;
            `CERC_ADDR_AUTO_BRIGHT:    rd_mux = auto_bright_ratio_reg;
            `CERC_ADDR_EXP_FMT:        rd_mux = exposure_format_ctrl_reg;
            `CERC_ADDR_V_OFFSET:       rd_mux = v_chan_offset_reg;
            `CERC_ADDR_DOUBLER_VREF:   rd_mux = doubler_vref_ctrl_reg;
            `CERC_ADDR_VREF_CURRENT:   rd_mux = vref_current_ctrl_reg;
            `CERC_ADDR_WORK_MODE:      rd_mux = sensor_work_mode_reg;
            `CERC_ADDR_DRIVE_STRENGTH: rd_mux = drive_strength_ctrl_reg;
            default:                   rd_mux = 8'h00;
        endcase
    end

    // Serial engine: host shifts MSB first on rising link clock edges;
    // read data is shifted out on falling edges so it is stable at the next rise.
    always @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            state_reg        <= ST_CMD;
            bit_cnt_reg      <= 3'd0;
            shift_reg        <= 8'h00;
            rd_reg           <= 1'b0;
            addr_reg         <= 8'h00;
            rd_data_reg      <= 8'h00;
            wr_stb_reg       <= 1'b0;
            wr_data_reg      <= 8'h00;
            link_data_out    <= 1'b0;
            link_data_oe_out <= 1'b0;
        end else if (clk_en_in) begin
            wr_stb_reg <= 1'b0;
            if (!sel_act) begin
                state_reg        <= ST_CMD;
                bit_cnt_reg      <= 3'd0;
                link_data_oe_out <= 1'b0;
            end else if (clk_rise) begin
                shift_reg   <= {shift_reg[6:0], dat_sync_reg[1]};
                bit_cnt_reg <= bit_cnt_reg + 3'd1;
                if (bit_cnt_reg == 3'd7) begin
                    case (state_reg)
                        ST_CMD: begin
                            rd_reg    <= shift_reg[6];
                            state_reg <= ST_ADDR;
                        end
                        ST_ADDR: begin
                            addr_reg  <= {shift_reg[6:0], dat_sync_reg[1]};
                            state_reg <= ST_DATA;
                        end
                        ST_DATA: begin
                            if (!rd_reg) begin
                                wr_data_reg <= {shift_reg[6:0], dat_sync_reg[1]};
                                wr_stb_reg  <= 1'b1;
                            end
                            state_reg <= ST_DONE;
                        end
                        default: state_reg <= ST_DONE;
                    endcase
                end
            end else if (clk_fall && state_reg == ST_DATA && rd_reg) begin
                // First falling edge of data phase loads, later ones shift.
                if (bit_cnt_reg == 3'd0) begin
                    link_data_out    <= rd_mux[7];
                    rd_data_reg      <= {rd_mux[6:0], 1'b0};
                    link_data_oe_out <= 1'b1;
                end else begin
                    link_data_out <= rd_data_reg[7];
                    rd_data_reg   <= {rd_data_reg[6:0], 1'b0};
                end
            end else if (clk_fall && state_reg == ST_DONE) begin
                link_data_oe_out <= 1'b0;
            end
        end
    end

    // Register writes. Reference and work-mode registers are plain storage;
    // the host is expected to keep their defaults.
    always @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            stats_ctrl_reg           <= `CERC_RST_STATS_CTRL;
            frame_rate_adj_hi_reg    <= `CERC_RST_FR_ADJ_HI;
            frame_rate_adj_lo_reg    <= `CERC_RST_FR_ADJ_LO;
            auto_bright_ratio_reg    <= `CERC_RST_AUTO_BRIGHT;
            exposure_format_ctrl_reg <= `CERC_RST_EXP_FMT;
            v_chan_offset_reg        <= `CERC_RST_V_OFFSET;
            doubler_vref_ctrl_reg    <= `CERC_RST_DOUBLER_VREF;
            vref_current_ctrl_reg    <= `CERC_RST_VREF_CURRENT;
            sensor_work_mode_reg     <= `CERC_RST_WORK_MODE;
            drive_strength_ctrl_reg  <= `CERC_RST_DRIVE_STRENGTH;
        end else if (clk_en_in) begin
            // Internal logic owns the V offset unless the host source is chosen.
            if (!offset_source_in) begin
                v_chan_offset_reg <= int_v_offset_in;
            end else if (wr_stb_reg && addr_reg == `CERC_ADDR_V_OFFSET) begin
                v_chan_offset_reg <= wr_data_reg;
            end
            if (wr_stb_reg) begin
                case (addr_reg)
                    `CERC_ADDR_STATS_CTRL:
                        stats_ctrl_reg <= {wr_data_reg[7:2], `CERC_REVISION};
                    `CERC_ADDR_FR_ADJ_HI:      frame_rate_adj_hi_reg    <= wr_data_reg;
                    `CERC_ADDR_FR_ADJ_LO:      frame_rate_adj_lo_reg    <= wr_data_reg;
                    `CERC_ADDR_AUTO_BRIGHT:    auto_bright_ratio_reg    <= wr_data_reg;
                    `CERC_ADDR_EXP_FMT:        exposure_format_ctrl_reg <= wr_data_reg;
                    `CERC_ADDR_DOUBLER_VREF:   doubler_vref_ctrl_reg    <= wr_data_reg;
                    `CERC_ADDR_VREF_CURRENT:   vref_current_ctrl_reg    <= wr_data_reg;
                    `CERC_ADDR_WORK_MODE:      sensor_work_mode_reg     <= wr_data_reg;
                    `CERC_ADDR_DRIVE_STRENGTH: drive_strength_ctrl_reg  <= wr_data_reg;
                    default: ;
                endcase
            end
        end
    end

    // Derived control values, computed combinationally and registered below.
    wire [9:0] fr_ctrl = {frame_rate_adj_hi_reg[`CERC_FRH_CTRL_MSB:`CERC_FRH_CTRL_LSB],
                          frame_rate_adj_lo_reg};
    wire [9:0] fr_applied = frame_rate_adj_hi_reg[`CERC_FRH_ENABLE_BIT] ?
                            fr_ctrl : 10'h000;
    // Thresholds are summed at five bits so the top case cannot wrap.
    wire [4:0] thr_lo  = {1'b0, auto_bright_ratio_reg[3:0]};
    wire [4:0] thr_sum = thr_lo + {1'b0, auto_bright_ratio_reg[7:4]};
    wire       dark_hi = dark_share_in > {3'b000, thr_sum};
    wire       dark_lo = dark_share_in < {4'b0000, thr_lo};
    wire [8:0] v_mag   = {2'b00, v_chan_offset_reg[6:0]};
    wire [8:0] v_signed = v_chan_offset_reg[`CERC_VOFF_DIR_BIT] ?
                          (9'd0 - v_mag) : v_mag;

    // Field counter for the slow exposure update option.
    reg [1:0] field_cnt_reg;

    always @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            field_cnt_reg      <= 2'd0;
            center_stats_out   <= 1'b0;
            dbl_clk_out        <= 1'b0;
            fr_reduce_out      <= 10'h000;
            fr_reduce_cpct_out <= 14'h0000;
            uv_delay_out       <= 2'd0;
            y_manual_out       <= 1'b0;
            one_frame_out      <= 1'b0;
            avg_luma_out       <= 1'b0;
            bright_dec_out     <= 1'b0;
            bright_inc_out     <= 1'b0;
            exp_update_out     <= 1'b0;
            odd_field_only_out <= 1'b0;
            black_expand_out   <= 1'b0;
            band_filter_out    <= 1'b0;
            v_offset_out       <= 9'h000;
            r_offset_sel_out   <= 1'b0;
        end else if (clk_en_in) begin
            center_stats_out   <= stats_ctrl_reg[`CERC_STATS_CENTER_BIT];
            dbl_clk_out        <= stats_ctrl_reg[`CERC_STATS_DBL_CLK_BIT];
            fr_reduce_out      <= fr_applied;
            fr_reduce_cpct_out <= fr_applied * `CERC_FR_STEP_CENTI_PCT;
            uv_delay_out       <= frame_rate_adj_hi_reg[`CERC_FRH_UV_DELAY_BIT] ?
                                  `CERC_UV_DELAY_PIX : 2'd0;
            y_manual_out       <= frame_rate_adj_hi_reg[`CERC_FRH_Y_MANUAL_BIT] &
                                  manual_bright_in;
            one_frame_out      <= frame_rate_adj_hi_reg[`CERC_FRH_ONE_FRAME_BIT] &
                                  frame_exposure_in;
            avg_luma_out       <= frame_rate_adj_hi_reg[`CERC_FRH_AVG_LUMA_BIT];
            bright_dec_out     <= dark_hi;
            bright_inc_out     <= dark_lo;
            // Neither flag set means the level holds.
            // Slow mode updates every fourth field; every second is left to the
            // sensor timing since only one bit chooses.
            exp_update_out     <= 1'b0;
            if (field_start_in) begin
                field_cnt_reg <= field_cnt_reg + 2'd1;
                exp_update_out <= !exposure_format_ctrl_reg[`CERC_EXP_SLOW_UPD_BIT] ||
                                  (field_cnt_reg == 2'd0);
            end
            odd_field_only_out <= exposure_format_ctrl_reg[`CERC_EXP_QUARTER_BIT];
            black_expand_out   <= exposure_format_ctrl_reg[`CERC_EXP_BLACK_EXP_BIT];
            band_filter_out    <= exposure_format_ctrl_reg[`CERC_EXP_BAND_BIT];
            v_offset_out       <= manual_bright_in ? 9'h000 : v_signed;
            r_offset_sel_out   <= raw_rgb_in & ~manual_bright_in;
        end
    end

endmodule // cerc_regs

// file: test/cerc_host_model.sv
// Purpose: Host model that frames register accesses on the serial link.
// Assumes: Link clock of 8 system cycles, idle low, data launched while low.
// Notes:   A released data line shows a toggling pattern, never a held value.
`timescale 1ns/10ps
module cerc_host_model (
    input  wire clk_sys_in,  // System clock.
    input  wire dev_data_in, // Device data drive.
    input  wire dev_oe_in,   // Device drive enable.
    output reg  lclk_out,    // Link clock, idle low.
    output reg  sel_n_out,   // Frame select, active low.
    output wire data_out     // Resolved data line.
);
    reg bit_q;
    reg drv_en;
    reg last_q;
    // The undriven line toggles so the simulator cannot invent a stable bit.
    assign data_out = dev_oe_in ? dev_data_in : (drv_en ? bit_q : ~last_q);
    initial begin
        lclk_out = 1'b0;
        sel_n_out = 1'b1;
        bit_q = 1'b0;
        drv_en = 1'b1;
        last_q = 1'b0;
    end
    // Remember the line so a release can show its inverse.
    always @(posedge clk_sys_in) begin
        last_q <= data_out;
    end
    // One whole frame: command, address, data, most significant bit first; writes to 8'h30 and 8'h31 send no frame.
    task automatic xfer(input [7:0] cmd, input [7:0] addr, input [7:0] wd, output [7:0] rd);
        reg [23:0] sh;
        integer    i;
        sh = {cmd, addr, wd};
        rd = 8'h00;
        if (!cmd[7] && (addr == 8'h30 || addr == 8'h31)) return;
        @(posedge clk_sys_in) sel_n_out <= 1'b0;
        for (i = 23; i >= 0; i = i - 1) begin
            drv_en <= !(cmd[7] && i < 8);
            bit_q <= sh[i];
            repeat (4) @(posedge clk_sys_in);
            lclk_out <= 1'b1;
            repeat (3) @(posedge clk_sys_in);
            #1;
            if (i < 8) rd[i] = data_out;
            @(posedge clk_sys_in) lclk_out <= 1'b0;
        end
        repeat (4) @(posedge clk_sys_in);
        sel_n_out <= 1'b1;
        drv_en <= 1'b1;
        repeat (8) @(posedge clk_sys_in);
    endtask
endmodule // cerc_host_model

// file: test/cerc_regs_sva.sv
// Purpose: Port-level assertions for the exposure and rate register slice.
// Assumes: Outputs are registered one cycle behind their sources.
// Notes:   Checks that use past values wait a few cycles after reset while internal reset drains.
`timescale 1ns/10ps
module cerc_regs_sva (
    input wire        clk_sys_in, nrst_in, clk_en_in, frame_exposure_in,
    input wire        manual_bright_in, raw_rgb_in, field_start_in,
    input wire [9:0]  fr_reduce_out,
    input wire [13:0] fr_reduce_cpct_out,
    input wire [1:0]  uv_delay_out,
    input wire        y_manual_out, one_frame_out, bright_dec_out, bright_inc_out,
    input wire        exp_update_out, r_offset_sel_out,
    input wire [8:0]  v_offset_out
);
    reg  [2:0] age_q;
    wire       live;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);
    // Count edges after release so past values never reach back into reset.
    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) age_q <= 3'h0;
        else if (age_q != 3'h7) age_q <= age_q + 3'h1;
    end
    assign live = (age_q == 3'h7);
    sequence s_upd_cause;
        field_start_in ##1 exp_update_out;
    endsequence
    a_cpct_scale: assert property (fr_reduce_cpct_out == fr_reduce_out * 14'd12)
        else $error("percent output not twelve times count");
    a_bright_excl: assert property (!(bright_inc_out && bright_dec_out))
        else $error("brightness raised and lowered together");
    a_uv_delay: assert property (uv_delay_out == 2'd0 || uv_delay_out == 2'd2)
        else $error("chroma delay not zero or two");
    a_upd_single: assert property (exp_update_out |=> !exp_update_out)
        else $error("update pulse longer than one cycle");
    a_upd_cause: assert property (live && exp_update_out |->
        $past(field_start_in && clk_en_in))
        else $error("update pulse without field start");
    a_red_select: assert property (live && $past(clk_en_in) |->
        r_offset_sel_out == $past(raw_rgb_in && !manual_bright_in))
        else $error("red channel select wrong");
    a_voff_zero: assert property (live && $past(manual_bright_in && clk_en_in) |->
        v_offset_out == 9'h000)
        else $error("offset active under manual brightness");
    a_one_frame: assert property (live && $past(clk_en_in) && one_frame_out |->
        $past(frame_exposure_in))
        else $error("single frame without frame exposure");
    a_y_manual: assert property (live && $past(clk_en_in) && y_manual_out |->
        $past(manual_bright_in))
        else $error("manual luma without control bit");
    cover property (s_upd_cause);
endmodule // cerc_regs_sva
bind cerc_regs cerc_regs_sva u_sva (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .clk_en_in(clk_en_in), .frame_exposure_in(frame_exposure_in),
    .manual_bright_in(manual_bright_in), .raw_rgb_in(raw_rgb_in),
    .field_start_in(field_start_in), .fr_reduce_out(fr_reduce_out),
    .fr_reduce_cpct_out(fr_reduce_cpct_out), .uv_delay_out(uv_delay_out),
    .y_manual_out(y_manual_out), .one_frame_out(one_frame_out),
    .bright_dec_out(bright_dec_out), .bright_inc_out(bright_inc_out),
    .exp_update_out(exp_update_out), .r_offset_sel_out(r_offset_sel_out),
    .v_offset_out(v_offset_out));

// file: test/tb_top.sv
// Purpose: Self-checking bench for the exposure and rate register slice.
// Assumes: Registers are reached only through the serial link host model.
// Notes:   Link clock is 320 ns, eight system cycles, idle low between frames.
`timescale 1ns/10ps
module tb_top;
    reg         clk_sys_in, nrst_in, fexp, mbr, osrc, rawc, fstart, cen;
    reg  [7:0]  dshare, ivoff, rdv;
    wire        lclk, seln, ldat, dout, doe, cst, dbl, ymn, onef, avgl, bdec, binc;
    wire        upd, oddf, blk, band, rsel;
    wire [9:0]  frr;
    wire [13:0] frc;
    wire [1:0]  uvd;
    wire [8:0]  voff;
    integer     num_errors, checks_done, upd_cnt, i;
    reg  [7:0]  rst_tab [0:10];
    cerc_regs DUT (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .clk_en_in(cen),
        .link_clk_in(lclk), .link_data_in(ldat), .link_sel_n_in(seln),
        .frame_exposure_in(fexp), .manual_bright_in(mbr), .offset_source_in(osrc),
        .raw_rgb_in(rawc), .field_start_in(fstart), .dark_share_in(dshare),
        .int_v_offset_in(ivoff), .link_data_out(dout), .link_data_oe_out(doe),
        .center_stats_out(cst), .dbl_clk_out(dbl), .fr_reduce_out(frr),
        .fr_reduce_cpct_out(frc), .uv_delay_out(uvd), .y_manual_out(ymn),
        .one_frame_out(onef), .avg_luma_out(avgl), .bright_dec_out(bdec),
        .bright_inc_out(binc), .exp_update_out(upd), .odd_field_only_out(oddf),
        .black_expand_out(blk), .band_filter_out(band), .v_offset_out(voff),
        .r_offset_sel_out(rsel));
    cerc_host_model u_host (.clk_sys_in(clk_sys_in), .dev_data_in(dout), .dev_oe_in(doe),
        .lclk_out(lclk), .sel_n_out(seln), .data_out(ldat));
    // Free-running system clock, 40 ns period.
    initial begin
        clk_sys_in = 1'b0;
        forever #20 clk_sys_in = ~clk_sys_in;
    end
    // Count update pulses so field-rate ratios can be compared later.
    always @(posedge clk_sys_in) begin
        if (upd) upd_cnt <= upd_cnt + 1;
    end
    task chk(input [8*12-1:0] name, input [13:0] exp, input [13:0] got);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("wrong value %0s expected %h seen %h", name, exp, got);
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        u_host.xfer(8'h00, a, d, rdv);
    endtask
    task rd(input [7:0] a, input [7:0] exp);
        u_host.xfer(8'h80, a, 8'h00, rdv);
        chk("read data", {6'h0, exp}, {6'h0, rdv});
    endtask
    // Settle a few edges, then step off the edge before sampling.
    task settle;
        repeat (3) @(posedge clk_sys_in);
        #1;
    endtask
    task fields(input integer n);
        repeat (n) begin
            @(posedge clk_sys_in) fstart <= 1'b1;
            @(posedge clk_sys_in) fstart <= 1'b0;
            repeat (6) @(posedge clk_sys_in);
        end
    endtask
    task conclude;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Watchdog: the whole run needs well under a millisecond.
    initial begin
        #2000000;
        num_errors = num_errors + 1;
        conclude;
    end
    initial begin
        {nrst_in, fexp, mbr, osrc, rawc, fstart} = 6'h00;
        cen = 1'b1;
        dshare = 8'h00;
        ivoff = 8'h55;
        num_errors = 0;
        checks_done = 0;
        upd_cnt = 0;
        rst_tab = '{8'h34, 8'h00, 8'h00, 8'h88, 8'h81, 8'h55, 8'h31, 8'h38, 8'h60, 8'h06, 8'h00};
        repeat (3) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        repeat (6) @(posedge clk_sys_in);
        // Reset values, internal offset copy and an unmapped address.
        for (i = 0; i < 11; i = i + 1) rd(8'h29 + i[7:0], rst_tab[i]);
        wr(8'h29, 8'hff);
        rd(8'h29, 8'hfc);
        chk("centre", 14'h1, {13'h0, cst});
        chk("dbl clock", 14'h1, {13'h0, dbl});
        wr(8'h2b, 8'h34);
        wr(8'h2a, 8'h7b);
        @(posedge clk_sys_in) {mbr, fexp} <= 2'b11;
        settle;
        chk("rate off", 14'h0, {4'h0, frr});
        chk("uv delay", 14'h2, {12'h0, uvd});
        chk("y manual", 14'h1, {13'h0, ymn});
        chk("one frame", 14'h1, {13'h0, onef});
        chk("avg luma", 14'h1, {13'h0, avgl});
        wr(8'h2a, 8'hfb);
        chk("rate count", 14'h334, {4'h0, frr});
        chk("rate pct", 14'h334 * 14'd12, frc);
        wr(8'h2c, 8'h32);
        rd(8'h2c, 8'h32);
        for (i = 0; i < 4; i = i + 1) begin
            @(posedge clk_sys_in) dshare <= (i < 2) ? i[7:0] + 8'd1 : i[7:0] + 8'd3;
            settle;
            chk("bright inc", {13'h0, dshare < 8'd2}, {13'h0, binc});
            chk("bright dec", {13'h0, dshare > 8'd5}, {13'h0, bdec});
        end
        wr(8'h2d, 8'h54);
        chk("odd field", 14'h1, {13'h0, oddf});
        chk("black exp", 14'h1, {13'h0, blk});
        chk("band filt", 14'h1, {13'h0, band});
        upd_cnt = 0;
        fields(4);
        chk("upd every", 14'd4, upd_cnt[13:0]);
        wr(8'h2d, 8'hd4);
        upd_cnt = 0;
        fields(8);
        chk("upd slow", 14'd2, upd_cnt[13:0]);
        @(posedge clk_sys_in) mbr <= 1'b0;
        wr(8'h2e, 8'h0a);
        rd(8'h2e, 8'h55);
        chk("v offset", 14'h055, {5'h0, voff});
        @(posedge clk_sys_in) osrc <= 1'b1;
        wr(8'h2e, 8'h85);
        rd(8'h2e, 8'h85);
        chk("v offset", 14'h1fb, {5'h0, voff});
        @(posedge clk_sys_in) rawc <= 1'b1;
        settle;
        chk("red select", 14'h1, {13'h0, rsel});
        @(posedge clk_sys_in) mbr <= 1'b1;
        settle;
        chk("v off idle", 14'h0, {5'h0, voff});
        chk("red select", 14'h0, {13'h0, rsel});
        // With the clock enable low the outputs must keep their last values.
        @(posedge clk_sys_in) {cen, mbr} <= 2'b00;
        settle;
        chk("v off held", 14'h0, {5'h0, voff});
        chk("red held", 14'h0, {13'h0, rsel});
        @(posedge clk_sys_in) cen <= 1'b1;
        settle;
        chk("v off run", 14'h1fb, {5'h0, voff});
        chk("red run", 14'h1, {13'h0, rsel});
        conclude;
    end
endmodule // tb_top
